//--- shared/crs_pkg.sv
package crs_pkg;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [7:0] CRS_A_CTRL = 8'h00;
	localparam logic [7:0] CRS_A_CMD  = 8'h04;
	localparam logic [7:0] CRS_A_STAT = 8'h08;
	localparam logic [7:0] CRS_A_DIAG = 8'h0C;
	localparam logic [7:0] CRS_A_IRQ  = 8'h10;
	localparam logic [7:0] CRS_A_MASK = 8'h14;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CRS_CTRL_RECOV_WARM = 0; // Leave Not Ready by warm start
	localparam int CRS_CTRL_BOOT_RUN   = 1; // Module boot start condition
	localparam int CRS_CMD_WARM        = 0;
	localparam int CRS_CMD_COLD        = 1;
	localparam int CRS_CMD_DL_START    = 2;
	localparam int CRS_CMD_DL_END      = 3;
	localparam int CRS_EV_OP_CHANGE    = 0;
	localparam int CRS_EV_WARM_DONE    = 1;
	localparam int CRS_EV_DL_DONE      = 2;
	localparam int CRS_EV_DIAG_ERR     = 3;
	localparam int CRS_EV_REFUSED      = 4;
	localparam int CRS_NEV             = 5;
	localparam int CRS_DIAG_W          = 16;
	localparam int CRS_DIAG_ERR_LO     = 8;

	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [1:0] CRS_CTRL_RST = 2'h0;
	localparam logic [CRS_NEV-1:0] CRS_MASK_RST = 5'h00;
	localparam logic [1:0] CRS_SEL_HALT = 2'h0;
	localparam logic [1:0] CRS_SEL_RUN  = 2'h1;
	localparam logic [1:0] CRS_SEL_MRST = 2'h2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {OP_RUN, OP_READY, OP_NREADY} crs_op_t;
	typedef enum logic [1:0] {PH_TEST, PH_COPY, PH_IDLE, PH_WARM} crs_ph_t;

	typedef struct packed {
		logic ready;
		logic run;
		logic not_ready;
		logic battery;
		logic in0;
	} crs_led_t;

	typedef struct packed {
		logic run;        // Program executes
		logic resume;     // Pulse: continue at interrupted point
		logic force_zero; // Outputs and comm data held at zero
		logic init_warm;  // Pulse: reinit, keep retentive data
		logic cold;       // Pulse: clear all data, restart at top
	} crs_core_t;

	typedef struct packed {
		crs_op_t               op;
		crs_ph_t               ph;
		logic                  dl;
		logic                  btn_q;
		logic [1:0]            ctrl;
		logic [CRS_DIAG_W-1:0] diag;
		logic [CRS_NEV-1:0]    irq;
		logic [CRS_NEV-1:0]    mask;
		logic [31:0]           rdata;
		crs_core_t             core;
	} crs_state_t;

endpackage

//--- src/crs_ctrl.sv
// Functional notes
// - Warm start resumes the program where interrupted, to end of cycle.
// - Outputs and communication data forced to zero for that remaining cycle.
// - Then reinitialize and run cyclically, retentive data kept.
// - Reset button warm-starts only with selector Run and state Ready, or Not Ready with recovery option warm.
// - Power-up warm start with selector Run only if battery is good.
// - PC warm start request honoured only in Ready state.
// - Recovery option warm with selector Run leaves Not Ready by warm start.
// - Download only in Ready or Not Ready, whatever the selector position.
// - Download with selector Halt lights Ready, Not Ready and input 0.0.
// - With memory module fitted, download writes RAM and module both.
// - Power-up with module copies module program, starts per configured condition.
// - Ready indicator on once self-test passed and ready to start.
// - Run indicator on while program executes, off when halted.
// - Not Ready indicator on for program missing, processor fault, serious error.
// - Battery indicator on for battery fault, off when healthy.
// - Status read hierarchically, summary diagnostic word first.
// - Summary word 16 bits; bits 8 to 15 force Not Ready.
// - Cold start clears all data areas and restarts program from beginning.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
module crs_ctrl
	import crs_pkg::*;
(
	// Clock and reset
	input  wire logic                  SYS_CLK,
	input  wire logic                  NRST,
	// APB slave
	input  wire logic                  PSEL,
	input  wire logic                  PENABLE,
	input  wire logic                  PWRITE,
	input  wire logic [7:0]            PADDR,
	input  wire logic [31:0]           PWDATA,
	output logic      [31:0]           PRDATA,
	output logic                       PREADY,
	output logic                       PSLVERR,
	// Operator panel
	input  wire logic [1:0]            MODE_SEL,
	input  wire logic                  RESET_BTN,
	// Platform status
	input  wire logic                  SELFTEST_DONE,
	input  wire logic                  BATT_OK,
	input  wire logic                  MODULE_PRESENT,
	input  wire logic                  MOD_COPY_DONE,
	// Execution core
	input  wire logic                  PROG_VALID,
	input  wire logic                  CORE_FAULT,
	input  wire logic                  CYCLE_END,
	input  wire logic [CRS_DIAG_W-1:0] DIAG_SET,
	output crs_core_t                  CORE,
	// Program memory writes
	output logic                       MOD_COPY_REQ,
	output logic                       DL_RAM_WE,
	output logic                       DL_MOD_WE,
	// Indicators and interrupt
	output crs_led_t                   LEDS,
	output logic                       IRQ
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	crs_state_t s;
	crs_state_t next_s;

	logic                  acc;
	logic                  wr;
	logic                  mapped;
	logic                  btn;
	logic                  err;
	logic                  sel_halt;
	logic                  sel_run;
	logic                  sel_mrst;
	logic [31:0]           cmd;
	logic [CRS_NEV-1:0]    ev;
	logic [CRS_NEV-1:0]    irq_clr;
	logic [CRS_DIAG_W-1:0] diag_clr;

	// Bus decode
	assign acc = PSEL & PENABLE;
	assign wr  = acc & PWRITE;
	assign mapped = (PADDR == CRS_A_CTRL) | (PADDR == CRS_A_CMD) |
		(PADDR == CRS_A_STAT) | (PADDR == CRS_A_DIAG) |
		(PADDR == CRS_A_IRQ) | (PADDR == CRS_A_MASK);
	assign cmd = (wr && PADDR == CRS_A_CMD) ? PWDATA : 32'h0000_0000;
	assign irq_clr = (wr && PADDR == CRS_A_IRQ) ? PWDATA[CRS_NEV-1:0]
		: '0;

	// Panel decode
	assign sel_halt = (MODE_SEL == CRS_SEL_HALT);
	assign sel_run  = (MODE_SEL == CRS_SEL_RUN);
	assign sel_mrst = (MODE_SEL == CRS_SEL_MRST);
	assign btn = RESET_BTN & ~s.btn_q;

	// Error class bits and faults force Not Ready
	assign err = (|s.diag[CRS_DIAG_W-1:CRS_DIAG_ERR_LO]) | CORE_FAULT |
		(~PROG_VALID & ~s.dl);

	// Acknowledge clears the diagnostic word
	always_comb begin
		diag_clr = '0;
		if (wr && PADDR == CRS_A_DIAG)
			diag_clr = PWDATA[CRS_DIAG_W-1:0];
		if (btn && s.ph == PH_IDLE && (sel_halt || s.op == OP_RUN))
			diag_clr = '1;
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		next_s = s;
		ev = '0;
		next_s.btn_q = RESET_BTN;
		next_s.core.resume = 1'b0;
		next_s.core.init_warm = 1'b0;
		next_s.core.cold = 1'b0;

		// Read data captured in the setup cycle
		if (PSEL && !PENABLE) begin
			case (PADDR)
				CRS_A_CTRL: next_s.rdata = {30'h0, s.ctrl};
				CRS_A_STAT: next_s.rdata = {26'h0, MOD_COPY_REQ, s.dl,
					s.ph, s.op};
				CRS_A_DIAG: next_s.rdata = {16'h0, s.diag};
				CRS_A_IRQ:  next_s.rdata = {27'h0, s.irq};
				CRS_A_MASK: next_s.rdata = {27'h0, s.mask};
				default:    next_s.rdata = 32'h0000_0000;
			endcase
		end

		// Configuration writes
		if (wr && PADDR == CRS_A_CTRL)
			next_s.ctrl = PWDATA[1:0];
		if (wr && PADDR == CRS_A_MASK)
			next_s.mask = PWDATA[CRS_NEV-1:0];

		// Operating sequence
		case (s.ph)
			PH_TEST: begin
				if (SELFTEST_DONE) begin
					if (MODULE_PRESENT) begin
						next_s.ph = PH_COPY;
					end else begin
						next_s.ph = PH_IDLE;
						if (!PROG_VALID) begin
							next_s.op = OP_NREADY;
						end else if (sel_mrst) begin
							next_s.op = OP_RUN;
							next_s.core.cold = 1'b1;
						end else if (sel_run && BATT_OK) begin
							next_s.op = OP_RUN;
							next_s.ph = PH_WARM;
							next_s.core.resume = 1'b1;
							next_s.core.force_zero = 1'b1;
						end else if (sel_run) begin
							next_s.op = OP_NREADY;
						end else begin
							next_s.op = OP_READY;
						end
					end
				end
			end
			PH_COPY: begin
				// Module program copied, selector ignored
				if (MOD_COPY_DONE) begin
					next_s.ph = PH_IDLE;
					if (s.ctrl[CRS_CTRL_BOOT_RUN]) begin
						next_s.op = OP_RUN;
						next_s.core.cold = 1'b1;
					end else begin
						next_s.op = OP_NREADY;
					end
				end
			end
			PH_WARM: begin
				// Remaining cycle runs with outputs zeroed
				if (CYCLE_END) begin
					next_s.core.force_zero = 1'b0;
					next_s.core.init_warm = 1'b1;
					next_s.ph = PH_IDLE;
					ev[CRS_EV_WARM_DONE] = 1'b1;
				end
			end
			PH_IDLE: begin
				if (err && s.op != OP_NREADY) begin
					next_s.op = OP_NREADY;
				end else if (btn) begin
					if (sel_halt) begin
						next_s.op = OP_READY;
					end else if (sel_mrst && s.op != OP_RUN) begin
						next_s.op = OP_RUN;
						next_s.core.cold = 1'b1;
					end else if (sel_run && !err &&
						(s.op == OP_READY ||
						(s.op == OP_NREADY &&
						s.ctrl[CRS_CTRL_RECOV_WARM]))) begin
						next_s.op = OP_RUN;
						next_s.ph = PH_WARM;
						next_s.core.resume = 1'b1;
						next_s.core.force_zero = 1'b1;
					end
				end else if (cmd[CRS_CMD_WARM]) begin
					if (s.op == OP_READY && !s.dl) begin
						next_s.op = OP_RUN;
						next_s.ph = PH_WARM;
						next_s.core.resume = 1'b1;
						next_s.core.force_zero = 1'b1;
					end else begin
						ev[CRS_EV_REFUSED] = 1'b1;
					end
				end else if (cmd[CRS_CMD_COLD]) begin
					if (s.op != OP_RUN && !s.dl && !err) begin
						next_s.op = OP_RUN;
						next_s.core.cold = 1'b1;
					end else begin
						ev[CRS_EV_REFUSED] = 1'b1;
					end
				end else if (cmd[CRS_CMD_DL_START]) begin
					if (s.op != OP_RUN) begin
						next_s.dl = 1'b1;
					end else begin
						ev[CRS_EV_REFUSED] = 1'b1;
					end
				end else if (cmd[CRS_CMD_DL_END] && s.dl) begin
					// New program needs a cold start
					next_s.dl = 1'b0;
					next_s.op = OP_READY;
					ev[CRS_EV_DL_DONE] = 1'b1;
				end
			end
			default: next_s.ph = PH_TEST;
		endcase

		next_s.core.run = (next_s.op == OP_RUN);

		// Sticky flags, set wins over clear
		ev[CRS_EV_OP_CHANGE] = (next_s.op != s.op);
		ev[CRS_EV_DIAG_ERR] = |DIAG_SET[CRS_DIAG_W-1:CRS_DIAG_ERR_LO];
		next_s.diag = (s.diag & ~diag_clr) | DIAG_SET;
		next_s.irq = (s.irq & ~irq_clr) | ev;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or negedge NRST) begin
		if (!NRST) begin
			s.op    <= OP_NREADY;
			s.ph    <= PH_TEST;
			s.dl    <= 1'b0;
			s.btn_q <= 1'b0;
			s.ctrl  <= CRS_CTRL_RST;
			s.diag  <= '0;
			s.irq   <= '0;
			s.mask  <= CRS_MASK_RST;
			s.rdata <= 32'h0000_0000;
			s.core  <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// APB answers in the first access cycle
	assign PREADY  = acc;
	assign PSLVERR = acc & ~mapped;
	assign PRDATA  = s.rdata;

	assign CORE = s.core;
	assign MOD_COPY_REQ = (s.ph == PH_COPY);
	assign DL_RAM_WE = s.dl;
	assign DL_MOD_WE = s.dl & MODULE_PRESENT;
	assign IRQ = |(s.irq & s.mask);

	// Indicators, all but battery dark during self-test
	assign LEDS.ready = (s.ph != PH_TEST) & ((s.op == OP_READY) |
		(s.dl & sel_halt));
	assign LEDS.run = s.core.run;
	assign LEDS.not_ready = (s.ph != PH_TEST) & ((s.op == OP_NREADY) |
		(s.dl & sel_halt));
	assign LEDS.battery = ~BATT_OK;
	assign LEDS.in0 = s.dl & sel_halt;

endmodule

//--- dv/crs_properties.sv
`timescale 1ns/1ns
module crs_properties
	import crs_pkg::*;
(
	// Clock and reset
	input wire logic        SYS_CLK,
	input wire logic        NRST,
	// Bus and panel
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic [7:0]  PADDR,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic [1:0]  MODE_SEL,
	// Platform and core
	input wire logic        BATT_OK,
	input wire logic        MODULE_PRESENT,
	input wire logic        CYCLE_END,
	input wire crs_core_t   CORE,
	input wire logic        DL_RAM_WE,
	input wire logic        DL_MOD_WE,
	input wire crs_led_t    LEDS
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_ready_zero_wait: assert property (PREADY == (PSEL && PENABLE))
		else $error("pready not in access cycle");
	a_unmapped_err: assert property (PSEL && PENABLE && PADDR > CRS_A_MASK |-> PSLVERR)
		else $error("unmapped access without error");
	a_resume_forces_zero: assert property (
		$rose(CORE.force_zero) |-> CORE.resume && CORE.run)
		else $error("warm start without resume");
	a_resume_one_pulse: assert property (CORE.resume |=> !CORE.resume)
		else $error("resume longer than one cycle");
	a_tail_ends_init: assert property (
		CORE.force_zero && CYCLE_END |=> !CORE.force_zero && CORE.init_warm)
		else $error("warm tail not closed by reinit");
	a_zero_while_run: assert property (CORE.force_zero |-> CORE.run)
		else $error("zero forcing outside execution");
	a_run_led_core: assert property (LEDS.run == CORE.run)
		else $error("run indicator disagrees");
	a_battery_led: assert property (LEDS.battery == !BATT_OK)
		else $error("battery indicator wrong");
	a_module_mirror: assert property (DL_MOD_WE == (DL_RAM_WE && MODULE_PRESENT))
		else $error("module write not mirrored");
	a_halt_dl_leds: assert property (
		DL_RAM_WE && $past(DL_RAM_WE) && MODE_SEL == CRS_SEL_HALT
		&& $past(MODE_SEL) == CRS_SEL_HALT |-> LEDS.ready && LEDS.not_ready && LEDS.in0)
		else $error("download indicators wrong");

	c_warm: cover property (CORE.force_zero && CYCLE_END);
	c_cold: cover property (CORE.cold);
	c_download: cover property (DL_MOD_WE);
endmodule

bind crs_ctrl crs_properties chk_u (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .MODE_SEL(MODE_SEL),
	.BATT_OK(BATT_OK), .MODULE_PRESENT(MODULE_PRESENT), .CYCLE_END(CYCLE_END), .CORE(CORE),
	.DL_RAM_WE(DL_RAM_WE), .DL_MOD_WE(DL_MOD_WE), .LEDS(LEDS));

//--- dv/crs_pc_model.sv
`timescale 1ns/1ns
module crs_pc_model
	import crs_pkg::*;
(
	// Clock
	input wire logic        SYS_CLK,
	// APB master
	output logic            PSEL,
	output logic            PENABLE,
	output logic            PWRITE,
	output logic [7:0]      PADDR,
	output logic [31:0]     PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	// Operator panel
	output logic [1:0]      MODE_SEL,
	output logic            RESET_BTN
);
	// Idle bus, selector at halt
	initial begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		MODE_SEL = CRS_SEL_HALT;
		RESET_BTN = 1'b0;
	end

	// One transfer, held until pready; requests may come in any state
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge SYS_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		do @(posedge SYS_CLK); while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		PWDATA <= ~d; // Released data does not keep its value
	endtask

	// Selector move and button press
	task automatic set_sel(input logic [1:0] s);
		@(posedge SYS_CLK);
		MODE_SEL <= s;
	endtask
	task automatic press();
		@(posedge SYS_CLK);
		RESET_BTN <= 1'b1;
		@(posedge SYS_CLK);
		RESET_BTN <= 1'b0;
	endtask
endmodule

//--- dv/test_controller_restart_and_status.sv
`timescale 1ns/1ns
module test_controller_restart_and_status
	import crs_pkg::*;
;
	logic SYS_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RESET_BTN, IRQ;
	logic SELFTEST_DONE, BATT_OK, MODULE_PRESENT, PROG_VALID, CYCLE_END;
	logic DL_RAM_WE, DL_MOD_WE;
	logic MOD_COPY_DONE, CORE_FAULT, MOD_COPY_REQ;
	logic [1:0] MODE_SEL;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, PRDATA, r;
	logic [15:0] DIAG_SET;
	crs_core_t CORE;
	crs_led_t LEDS;
	int n_errors = 0;
	int comparisons = 0;

	crs_ctrl dut_u (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .MODE_SEL(MODE_SEL), .RESET_BTN(RESET_BTN),
		.SELFTEST_DONE(SELFTEST_DONE), .BATT_OK(BATT_OK), .MODULE_PRESENT(MODULE_PRESENT),
		.MOD_COPY_DONE(MOD_COPY_DONE), .PROG_VALID(PROG_VALID), .CORE_FAULT(CORE_FAULT),
		.CYCLE_END(CYCLE_END), .DIAG_SET(DIAG_SET), .CORE(CORE), .MOD_COPY_REQ(MOD_COPY_REQ),
		.DL_RAM_WE(DL_RAM_WE), .DL_MOD_WE(DL_MOD_WE), .LEDS(LEDS), .IRQ(IRQ));
	crs_pc_model pc_u (.SYS_CLK(SYS_CLK), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .MODE_SEL(MODE_SEL), .RESET_BTN(RESET_BTN));

	// ----------------------------------------
	// Clock, watchdog, shared tasks
	// ----------------------------------------
	initial begin
		SYS_CLK = 1'b0;
		forever #25 SYS_CLK = ~SYS_CLK;
	end
	initial begin
		#500000;
		n_errors++;
		test_done();
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		pc_u.xfer(1'b1, a, d, x, e);
		repeat (2) @(posedge SYS_CLK);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic e;
		pc_u.xfer(1'b0, a, 32'h0, r, e);
		chk(r, exp);
		chk({31'h0, e}, {31'h0, a > CRS_A_MASK});
	endtask
	task automatic test_done();
		if (n_errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic scen_warm();
		pc_u.set_sel(CRS_SEL_RUN);
		pc_u.press();
		@(posedge SYS_CLK iff CORE.resume === 1'b1);
		chk({CORE.force_zero, LEDS.run}, 2'h3);
		CYCLE_END <= 1'b1;
		@(posedge SYS_CLK);
		CYCLE_END <= 1'b0;
		chk(CORE.force_zero, 1'b1);
		@(posedge SYS_CLK);
		chk({CORE.force_zero, CORE.init_warm}, 2'h1);
		rd(CRS_A_STAT, 32'h00000008);
		wr(CRS_A_CMD, 32'h1);
		wr(CRS_A_CMD, 32'h4);
		wr(CRS_A_MASK, 32'h10);
		rd(CRS_A_IRQ, 32'h00000013);
		chk(IRQ, 1'b1);
		wr(CRS_A_IRQ, 32'h1F);
		chk(IRQ, 1'b0);
		rd(CRS_A_STAT, 32'h00000008);
	endtask

	task automatic scen_diag();
		DIAG_SET <= 16'h0001;
		@(posedge SYS_CLK);
		DIAG_SET <= 16'h0100;
		@(posedge SYS_CLK);
		DIAG_SET <= 16'h0000;
		repeat (3) @(posedge SYS_CLK);
		rd(CRS_A_DIAG, 32'h00000101);
		rd(CRS_A_STAT, 32'h0000000A);
		chk({LEDS.run, LEDS.not_ready}, 2'h1);
	endtask

	task automatic scen_download();
		logic e;
		MODULE_PRESENT <= 1'b1;
		pc_u.set_sel(CRS_SEL_HALT);
		wr(CRS_A_CMD, 32'h4);
		chk({DL_RAM_WE, DL_MOD_WE}, 2'h3);
		chk({LEDS.ready, LEDS.not_ready, LEDS.in0}, 3'h7);
		wr(CRS_A_DIAG, 32'h0101);
		wr(CRS_A_CMD, 32'h8);
		rd(CRS_A_STAT, 32'h00000009);
		pc_u.xfer(1'b1, CRS_A_CMD, 32'h2, r, e);
		@(posedge SYS_CLK iff CORE.cold === 1'b1);
		chk(CORE.resume, 1'b0);
		rd(CRS_A_STAT, 32'h00000008);
	endtask

	// Mid-run reset, module boot, fault, recovery by warm start
	task automatic scen_boot();
		NRST <= 1'b0;
		@(posedge SYS_CLK);
		chk({LEDS, CORE}, 10'h000);
		NRST <= 1'b1;
		@(posedge SYS_CLK iff MOD_COPY_REQ === 1'b1);
		chk({LEDS.ready, LEDS.not_ready}, 2'h1);
		wr(CRS_A_CTRL, 32'h2);
		MOD_COPY_DONE <= 1'b1;
		@(posedge SYS_CLK iff CORE.cold === 1'b1);
		MOD_COPY_DONE <= 1'b0;
		chk({CORE.run, MOD_COPY_REQ}, 2'h2);
		CORE_FAULT <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		CORE_FAULT <= 1'b0;
		chk({LEDS.run, LEDS.not_ready}, 2'h1);
		wr(CRS_A_CTRL, 32'h3);
		pc_u.set_sel(CRS_SEL_RUN);
		pc_u.press();
		@(posedge SYS_CLK iff CORE.resume === 1'b1);
		chk({CORE.force_zero, CORE.run}, 2'h3);
	endtask

	initial begin
		{NRST, SELFTEST_DONE, MODULE_PRESENT, CYCLE_END, DIAG_SET} = '0;
		{MOD_COPY_DONE, CORE_FAULT} = 2'h0;
		{BATT_OK, PROG_VALID} = 2'h3;
		repeat (3) @(posedge SYS_CLK);
		chk(LEDS, 5'h00);
		NRST <= 1'b1;
		rd(CRS_A_CTRL, 32'h0);
		rd(CRS_A_MASK, 32'h0);
		rd(8'h18, 32'h0);
		SELFTEST_DONE <= 1'b1;
		BATT_OK <= 1'b0;
		repeat (3) @(posedge SYS_CLK);
		chk({LEDS.ready, LEDS.battery}, 2'h3);
		BATT_OK <= 1'b1;
		rd(CRS_A_STAT, 32'h00000009);
		scen_warm();
		scen_diag();
		scen_download();
		scen_boot();
		test_done();
	end
endmodule
